// ### design/dio_defs.svh
`ifndef DIO_DEFS_SVH
`define DIO_DEFS_SVH
// Notes on behaviour
// R1 - Port read: bit n is line n
// R2 - Bits above implemented lines read zero
// R3 - Input lines read external level
// R4 - Output lines with read-back read driven value
// R5 - Per-line direction bit, 1 output, reset input
// R6 - Port-wide direction command sets all lines
// R7 - One-port group takes low byte
// R8 - Two-port group: low byte to higher port
// R9 - Four-port group: bits 7:0 to port 3
// R10 - Group members update in one cycle
// R11 - Group write refused unless group is output
// R12 - Group write refused when group empty
// R13 - Line write sets one line, others kept
// R14 - Line write refused unless port is output
// R15 - Port write: bit n drives line n
// R16 - Narrow port discards unimplemented write bits
// R17 - Port write refused unless port is output
// R18 - Reset: all inputs, no groups
// R19 - Group read mirrors write order, one sample
// R20 - Refused write sets sticky flag and pulse
// R21 - Input lines pass two-flop synchroniser
`define DIO_ADDR_W        8
`define DIO_NPORT         4
`define DIO_PORT_W        8
`define DIO_PORT_LINES    16'h8888
`define DIO_READBACK      4'hF
`define DIO_OFF_LINE_DIR  8'h00
`define DIO_OFF_PORT_DIR  8'h04
`define DIO_OFF_LINE_WR   8'h08
`define DIO_OFF_ERR       8'h0C
`define DIO_PAGE_PORT     4'h1
`define DIO_PAGE_GRP      4'h2
`define DIO_LW_LINE_LSB   2
`define DIO_LW_STATE_BIT  8
`define DIO_PD_DIR_BIT    8
`define DIO_GC_FIRST_LSB  4
`define DIO_RESP_OKAY     2'h0
`define DIO_RESP_SLVERR   2'h2
`endif

// ### design/dio_pkg.sv
package dio_pkg;
  typedef enum logic [2:0] {
    DIO_G0 = 3'b000,
    DIO_G1 = 3'b001,
    DIO_G2 = 3'b010,
    DIO_G4 = 3'b100
  } dio_gsize_e;

  typedef struct packed {
    logic [1:0] first;
    dio_gsize_e size;
  } dio_grp_s;

  typedef struct packed {
    logic gcfg;
    logic gempty;
    logic gnout;
    logic line;
    logic port;
  } dio_err_s;
endpackage

// ### design/dio_bank.sv
`timescale 1ns/1ns
`include "dio_defs.svh"
module dio_bank #(
  parameter logic [15:0] PORT_LINES = `DIO_PORT_LINES,
  parameter logic [3:0]  READBACK   = `DIO_READBACK
) (
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  input  wire logic [`DIO_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  output logic [1:0]                  s_axi_bresp,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  input  wire logic [`DIO_ADDR_W-1:0] s_axi_araddr,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  output logic [31:0]                 s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  input  wire logic [31:0]            gpio_in,
  output logic [31:0]                 gpio_out,
  output logic [31:0]                 gpio_oe,
  output logic                        err_pulse,
  output dio_pkg::dio_err_s           err_flags
);
  import dio_pkg::*;

  logic [31:0]            in_s1;
  logic [31:0]            in_s2;
  logic [31:0]            dir_q;
  logic [31:0]            out_q;
  logic [31:0]            imp_mask;
  logic [31:0]            rd_port;
  logic [3:0]             port_out;
  dio_grp_s               grp_q [2];
  dio_err_s               err_q;
  dio_err_s               err_set;
  logic                   aw_hold;
  logic                   w_hold;
  logic [`DIO_ADDR_W-1:0] aw_q;
  logic [31:0]            wd_q;
  logic                   wr_go;
  logic                   rd_go;
  logic                   is_ldir;
  logic                   is_pdir;
  logic                   is_line;
  logic                   is_err;
  logic                   is_port;
  logic                   is_gcfg;
  logic                   is_gdat;
  logic [1:0]             wp;
  logic                   wg;
  logic [1:0]             lp;
  logic [2:0]             ln;
  dio_grp_s               new_cfg;
  logic [3:0]             wmem;
  logic                   wgrp_out;
  logic [31:0]            next_rdata;
  logic [1:0]             next_rresp;
  logic                   rd_empty;

  function automatic logic [3:0] members(input dio_grp_s c);
    case (c.size)
      DIO_G1:  members = 4'b0001 << c.first;
      DIO_G2:  members = 4'b0011 << c.first;
      DIO_G4:  members = 4'hF;
      default: members = 4'h0;
    endcase
  endfunction

  function automatic logic cfg_ok(input dio_grp_s c);
    case (c.size)
      DIO_G0:  cfg_ok = 1'b1;
      DIO_G1:  cfg_ok = 1'b1;
      DIO_G2:  cfg_ok = ~c.first[0];
      DIO_G4:  cfg_ok = (c.first == 2'd0);
      default: cfg_ok = 1'b0;
    endcase
  endfunction

  function automatic logic [7:0] gbyte(input dio_grp_s c, input logic [1:0] p, input logic [31:0] d);
    case (c.size)
      DIO_G2:  gbyte = (p == c.first) ? d[15:8] : d[7:0]; // R8
      DIO_G4:  gbyte = d[{~p, 3'b000} +: 8]; // R9
      default: gbyte = d[7:0]; // R7
    endcase
  endfunction

  // One sampled vector feeds every member, so the bytes are coherent
  function automatic logic [31:0] gread(input dio_grp_s c, input logic [31:0] r);
    logic [1:0] nx;
    nx = 2'(c.first + 2'd1);
    case (c.size)
      DIO_G1:  gread = {24'h0, r[{c.first, 3'b000} +: 8]};
      DIO_G2:  gread = {16'h0, r[{c.first, 3'b000} +: 8], r[{nx, 3'b000} +: 8]}; // R19
      DIO_G4:  gread = {r[7:0], r[15:8], r[23:16], r[31:24]}; // R19
      default: gread = 32'h0;
    endcase
  endfunction

  // Metastability guard; only in_s2 is read by logic
  always_ff @(posedge aclk) begin
    in_s1 <= gpio_in; // R21
    in_s2 <= in_s1; // R21
  end

  genvar p;
  generate
    for (p = 0; p < `DIO_NPORT; p++) begin : g_port
      logic [7:0] m;
      logic [7:0] d;
      assign m = 8'hFF >> (4'd8 - PORT_LINES[4*p +: 4]);
      assign d = dir_q[8*p +: 8];
      assign imp_mask[8*p +: 8] = m;
      assign port_out[p] = &(d | ~m);
      // Without read-back an output line can only report the pin level
      assign rd_port[8*p +: 8] = (READBACK[p] ? ((d & out_q[8*p +: 8]) | (~d & in_s2[8*p +: 8]))
                                              : in_s2[8*p +: 8]) & m; // R1 R2 R3 R4
    end
  endgenerate

  assign s_axi_awready = ~aw_hold & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_hold & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;
  assign wr_go = aw_hold & w_hold & ~s_axi_bvalid;
  assign rd_go = s_axi_arvalid & s_axi_arready;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold <= 1'b0;
      aw_q    <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_hold <= 1'b1;
      aw_q    <= s_axi_awaddr;
    end else if (wr_go) begin
      aw_hold <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_hold <= 1'b0;
      wd_q   <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_hold <= 1'b1;
      wd_q   <= s_axi_wdata;
    end else if (wr_go) begin
      w_hold <= 1'b0;
    end
  end

  always_comb begin
    is_ldir  = aw_q == `DIO_OFF_LINE_DIR;
    is_pdir  = aw_q == `DIO_OFF_PORT_DIR;
    is_line  = aw_q == `DIO_OFF_LINE_WR;
    is_err   = aw_q == `DIO_OFF_ERR;
    is_port  = aw_q[7:4] == `DIO_PAGE_PORT;
    is_gcfg  = (aw_q[7:4] == `DIO_PAGE_GRP) & ~aw_q[3];
    is_gdat  = (aw_q[7:4] == `DIO_PAGE_GRP) & aw_q[3];
    wp       = aw_q[3:2];
    wg       = aw_q[2];
    lp       = wd_q[1:0];
    ln       = wd_q[`DIO_LW_LINE_LSB +: 3];
    new_cfg  = dio_grp_s'(wd_q[`DIO_GC_FIRST_LSB +: 2] << 3 | {2'b00, wd_q[2:0]});
    wmem     = members(grp_q[wg]);
    wgrp_out = (wmem & ~port_out) == 4'h0;
    rd_empty = (s_axi_araddr[7:4] == `DIO_PAGE_GRP) & s_axi_araddr[3] & (grp_q[s_axi_araddr[2]].size == DIO_G0);
  end

  always_comb begin
    err_set.port   = wr_go & is_port & ~port_out[wp]; // R17
    err_set.line   = wr_go & is_line & ~port_out[lp]; // R14
    err_set.gnout  = wr_go & is_gdat & (wmem != 4'h0) & ~wgrp_out; // R11
    err_set.gempty = (wr_go & is_gdat & (wmem == 4'h0)) | (rd_go & rd_empty); // R12
    err_set.gcfg   = wr_go & is_gcfg & ~cfg_ok(new_cfg);
  end

  // Direction: port-wide command and per-line register share one store
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dir_q <= '0; // R18
    end else if (wr_go && is_ldir) begin
      dir_q <= wd_q & imp_mask; // R5
    end else if (wr_go && is_pdir) begin
      dir_q[{wd_q[1:0], 3'b000} +: 8] <= {8{wd_q[`DIO_PD_DIR_BIT]}} & imp_mask[{wd_q[1:0], 3'b000} +: 8]; // R6
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      grp_q[0] <= '{first: 2'd0, size: DIO_G0}; // R18
      grp_q[1] <= '{first: 2'd0, size: DIO_G0}; // R18
    end else if (wr_go && is_gcfg && cfg_ok(new_cfg)) begin
      grp_q[wg] <= new_cfg;
    end
  end

  // All member bytes load on the same edge, so lines never show a mix
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      out_q <= '0;
    end else if (wr_go && is_port && port_out[wp]) begin
      out_q[{wp, 3'b000} +: 8] <= wd_q[7:0] & imp_mask[{wp, 3'b000} +: 8]; // R15 R16
    end else if (wr_go && is_line && port_out[lp]) begin
      out_q[{lp, ln}] <= wd_q[`DIO_LW_STATE_BIT] & imp_mask[{lp, ln}]; // R13
    end else if (wr_go && is_gdat && (wmem != 4'h0) && wgrp_out) begin
      for (int i = 0; i < `DIO_NPORT; i++) begin
        if (wmem[i]) begin
          out_q[8*i +: 8] <= gbyte(grp_q[wg], 2'(i), wd_q) & imp_mask[8*i +: 8]; // R10
        end
      end
    end
  end

  assign gpio_out = out_q;
  assign gpio_oe  = dir_q;

  // Set wins over a same-cycle write-one-to-clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      err_q     <= '0;
      err_pulse <= 1'b0;
    end else begin
      err_q     <= (err_q & ~((wr_go & is_err) ? dio_err_s'(wd_q[4:0]) : dio_err_s'(5'h0))) | err_set; // R20
      err_pulse <= |err_set; // R20
    end
  end

  assign err_flags = err_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `DIO_RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (is_ldir | is_pdir | is_line | is_err | is_port | is_gcfg | is_gdat)
                      ? `DIO_RESP_OKAY : `DIO_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_comb begin
    next_rdata = 32'h0;
    next_rresp = `DIO_RESP_OKAY;
    if (s_axi_araddr == `DIO_OFF_LINE_DIR) begin
      next_rdata = dir_q;
    end else if (s_axi_araddr == `DIO_OFF_PORT_DIR) begin
      next_rdata = {28'h0, port_out};
    end else if (s_axi_araddr == `DIO_OFF_LINE_WR) begin
      next_rdata = 32'h0;
    end else if (s_axi_araddr == `DIO_OFF_ERR) begin
      next_rdata = {27'h0, err_q};
    end else if (s_axi_araddr[7:4] == `DIO_PAGE_PORT) begin
      next_rdata = {24'h0, rd_port[{s_axi_araddr[3:2], 3'b000} +: 8]};
    end else if ((s_axi_araddr[7:4] == `DIO_PAGE_GRP) && !s_axi_araddr[3]) begin
      next_rdata = {24'h0, 2'b00, grp_q[s_axi_araddr[2]].first, 1'b0, grp_q[s_axi_araddr[2]].size};
    end else if (rd_empty) begin
      next_rresp = `DIO_RESP_SLVERR;
    end else if (s_axi_araddr[7:4] == `DIO_PAGE_GRP) begin
      next_rdata = gread(grp_q[s_axi_araddr[2]], rd_port);
    end else begin
      next_rresp = `DIO_RESP_SLVERR;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= `DIO_RESP_OKAY;
    end else if (rd_go) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= next_rdata;
      s_axi_rresp  <= next_rresp;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_sync;
    $past(aresetn, 2) |-> in_s2 == $past(gpio_in, 2);
  endproperty
  a_sync: assert property (p_sync) else $error("input synchroniser depth wrong"); // R21

  property p_input_read;
    (dir_q[7:0] == 8'h00) |-> rd_port[7:0] == (in_s2[7:0] & imp_mask[7:0]);
  endproperty
  a_input_read: assert property (p_input_read) else $error("input port read wrong"); // R3

  property p_high_zero;
    (rd_port & ~imp_mask) == 32'h0;
  endproperty
  a_high_zero: assert property (p_high_zero) else $error("unimplemented bits read nonzero"); // R2

  property p_oe;
    (gpio_oe & ~imp_mask) == 32'h0;
  endproperty
  a_oe: assert property (p_oe) else $error("unimplemented line enabled"); // R5

  property p_port_refuse;
    (wr_go && is_port && !port_out[wp]) |=> $stable(out_q) && err_pulse && err_q.port;
  endproperty
  a_port_refuse: assert property (p_port_refuse) else $error("refused port write acted"); // R17

  property p_line_keep;
    (wr_go && is_line && port_out[lp]) |=> (out_q ^ $past(out_q)) == ($past(out_q ^ out_q) | (out_q ^ $past(out_q)))
      && ((out_q ^ $past(out_q)) & ~(32'h1 << $past({lp, ln}))) == 32'h0;
  endproperty
  a_line_keep: assert property (p_line_keep) else $error("line write disturbed other lines"); // R13

  property p_grp4;
    (wr_go && is_gdat && grp_q[wg].size == DIO_G4 && wgrp_out) |=>
      out_q == ({$past(wd_q[7:0]), $past(wd_q[15:8]), $past(wd_q[23:16]), $past(wd_q[31:24])} & imp_mask);
  endproperty
  a_grp4: assert property (p_grp4) else $error("four-port group write wrong"); // R9

  property p_grp_empty;
    (wr_go && is_gdat && wmem == 4'h0) |=> $stable(out_q) && err_q.gempty ##1 1'b1;
  endproperty
  a_grp_empty: assert property (p_grp_empty) else $error("empty group write acted"); // R12

  property p_grp_nout;
    (wr_go && is_gdat && wmem != 4'h0 && !wgrp_out) |=> $stable(out_q) && err_pulse;
  endproperty
  a_grp_nout: assert property (p_grp_nout) else $error("non-output group write acted"); // R11

  property p_sticky;
    err_pulse |-> err_q != 5'h0;
  endproperty
  a_sticky: assert property (p_sticky) else $error("error pulse without sticky flag"); // R20

  property p_reset_state;
    $rose(aresetn) |-> dir_q == 32'h0 && grp_q[0].size == DIO_G0 && grp_q[1].size == DIO_G0;
  endproperty
  a_reset_state: assert property (p_reset_state) else $error("reset state not input, ungrouped"); // R18

  property p_port_dir;
    (wr_go && is_pdir && !is_ldir) |=> port_out[$past(wd_q[1:0])] == $past(wd_q[`DIO_PD_DIR_BIT])
      || dir_q[{$past(wd_q[1:0]), 3'b000} +: 8] == 8'h00;
  endproperty
  a_port_dir: assert property (p_port_dir) else $error("port direction command failed"); // R6
endmodule

// ### sim/dio_ext.sv
`timescale 1ns/1ns
module dio_ext (
  input  wire logic [31:0] drive,
  input  wire logic [31:0] gpio_out,
  input  wire logic [31:0] gpio_oe,
  output logic      [31:0] gpio_in
);
  // Equipment drives only the lines that the bank leaves as inputs.
  // Driven lines show the bank's own level, as the shared wire would.
  always_comb begin
    gpio_in = (gpio_oe & gpio_out) | (~gpio_oe & drive);
  end
endmodule

// ### sim/digital_io_port_bank_tb.sv
`timescale 1ns/1ns
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin err_count++; \
  $display("BAD %0t mismatch got %h exp %h", $time, got, exp); end end
module digital_io_port_bank_tb;
  import dio_pkg::*;
  typedef struct {bit rd; logic [7:0] a; logic [31:0] d; logic [1:0] r;} dio_row_s;
  localparam int NR = 46;
  logic            aclk, aresetn;
  logic [7:0]      s_axi_awaddr, s_axi_araddr;
  logic [31:0]     s_axi_wdata, s_axi_rdata, gpio_in, gpio_out, gpio_oe, ext, prev_out;
  logic [1:0]      s_axi_bresp, s_axi_rresp, resp;
  logic            s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic            s_axi_arvalid, s_axi_arready, s_axi_rvalid, err_pulse;
  logic [31:0]     rdat;
  dio_err_s        err_flags;
  int              err_count, comparisons, pulses, changes, p0;
  dio_row_s        rows [0:NR-1];

  // Port 0 is four lines wide so the narrow-port masking is reached
  dio_bank #(.PORT_LINES(16'h8884), .READBACK(4'hF)) i_dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(1'b1), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(1'b1), .gpio_in(gpio_in), .gpio_out(gpio_out),
    .gpio_oe(gpio_oe), .err_pulse(err_pulse), .err_flags(err_flags));
  dio_ext i_ext (.drive(ext), .gpio_out(gpio_out), .gpio_oe(gpio_oe), .gpio_in(gpio_in));

  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end

  always @(posedge aclk) begin
    if (err_pulse === 1'b1) pulses++;
    if (gpio_out !== prev_out) changes++;
    prev_out <= gpio_out;
  end

  task automatic tally_and_finish();
    $display("counts: %0d comparisons, %0d mismatches", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // Ready is held high all run, so the answer is taken at the edge it is seen
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    bit aw, w;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    aw = 1;
    w = 1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      r = s_axi_bresp;
      if (aw && s_axi_awready === 1'b1) begin aw = 0; s_axi_awvalid <= 1'b0; end
      if (w && s_axi_wready === 1'b1) begin w = 0; s_axi_wvalid <= 1'b0; end
    end while (s_axi_bvalid !== 1'b1 && n < 50);
    if (n >= 50) begin err_count++; $display("BAD %0t write hangs", $time); tally_and_finish(); end
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      d = s_axi_rdata;
      r = s_axi_rresp;
      if (s_axi_arvalid === 1'b1 && s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && n < 50);
    if (n >= 50) begin err_count++; $display("BAD %0t read hangs", $time); tally_and_finish(); end
  endtask

  initial begin
    rows = '{
      '{1, 8'h0C, 32'h0, 2'h0}, '{1, 8'h10, 32'h0C, 2'h0}, '{1, 8'h14, 32'h5A, 2'h0},
      '{0, 8'h14, 32'h11, 2'h0}, '{1, 8'h0C, 32'h1, 2'h0}, '{0, 8'h0C, 32'h1F, 2'h0},
      '{0, 8'h04, 32'h101, 2'h0}, '{0, 8'h14, 32'hC7, 2'h0}, '{1, 8'h14, 32'hC7, 2'h0},
      '{0, 8'h08, 32'h09, 2'h0}, '{1, 8'h14, 32'hC3, 2'h0}, '{0, 8'h08, 32'h104, 2'h0},
      '{1, 8'h0C, 32'h2, 2'h0}, '{0, 8'h0C, 32'h1F, 2'h0}, '{0, 8'h28, 32'h1234, 2'h0},
      '{1, 8'h0C, 32'h8, 2'h0}, '{0, 8'h0C, 32'h1F, 2'h0}, '{0, 8'h20, 32'h22, 2'h0},
      '{0, 8'h28, 32'hBEEF, 2'h0}, '{1, 8'h0C, 32'h4, 2'h0}, '{0, 8'h0C, 32'h1F, 2'h0},
      '{0, 8'h04, 32'h102, 2'h0}, '{0, 8'h04, 32'h103, 2'h0}, '{0, 8'h28, 32'hBEEF, 2'h0},
      '{1, 8'h18, 32'hBE, 2'h0}, '{1, 8'h1C, 32'hEF, 2'h0}, '{1, 8'h28, 32'hBEEF, 2'h0},
      '{0, 8'h04, 32'h100, 2'h0}, '{1, 8'h00, 32'hFFFFFF0F, 2'h0}, '{0, 8'h10, 32'hFF, 2'h0},
      '{1, 8'h10, 32'h0F, 2'h0}, '{0, 8'h24, 32'h04, 2'h0}, '{0, 8'h2C, 32'h11223344, 2'h0},
      '{1, 8'h2C, 32'h01223344, 2'h0}, '{0, 8'h20, 32'h11, 2'h0}, '{0, 8'h28, 32'hABCD, 2'h0},
      '{1, 8'h14, 32'hCD, 2'h0}, '{1, 8'h40, 32'h0, 2'h2}, '{0, 8'h40, 32'h5, 2'h2},
      '{0, 8'h24, 32'h14, 2'h0}, '{1, 8'h0C, 32'h10, 2'h0}, '{1, 8'h24, 32'h04, 2'h0},
      '{0, 8'h0C, 32'h1F, 2'h0}, '{0, 8'h04, 32'h001, 2'h0}, '{1, 8'h14, 32'h5A, 2'h0},
      '{1, 8'h00, 32'hFFFF000F, 2'h0}};
    aresetn = 1'b0;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0;
    s_axi_awvalid = 1'b0;
    s_axi_wvalid = 1'b0;
    s_axi_arvalid = 1'b0;
    ext = 32'hA5C35A3C;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    `CHK(gpio_oe, 32'h0)
    `CHK(gpio_out, 32'h0)
    `CHK(err_flags, 5'h00)
    $display("test reset done");
    repeat (3) @(posedge aclk);
    for (int i = 0; i < NR; i++) begin
      if (rows[i].rd) begin
        axi_rd(rows[i].a, rdat, resp);
        `CHK(rdat, rows[i].d)
      end else begin
        axi_wr(rows[i].a, rows[i].d, resp);
        // A change to input reaches port reads only after the synchroniser
        repeat (2) @(posedge aclk);
      end
      `CHK(resp, rows[i].r)
    end
    $display("test table done");
    // Refused write: one pulse, sticky flag, directions untouched
    p0 = pulses;
    axi_wr(8'h14, 32'h77, resp);
    repeat (2) @(posedge aclk);
    `CHK(pulses - p0, 1)
    `CHK(err_flags, 5'h01)
    `CHK(gpio_oe, 32'hFFFF000F)
    axi_wr(8'h0C, 32'h1F, resp);
    $display("test refusal done");
    // Four-port write must land on all lines in a single step
    axi_wr(8'h04, 32'h101, resp);
    repeat (2) @(posedge aclk);
    p0 = changes;
    axi_wr(8'h2C, 32'hFFEEDDCC, resp);
    repeat (2) @(posedge aclk);
    `CHK(gpio_out, 32'hCCDDEE0F)
    `CHK(changes - p0, 1)
    $display("test group step done");
    // Pin change must not show before the synchroniser has passed it
    axi_wr(8'h04, 32'h001, resp);
    repeat (3) @(posedge aclk);
    ext <= 32'hA5C3963C;
    axi_rd(8'h14, rdat, resp);
    `CHK(rdat, 32'h5A)
    repeat (3) @(posedge aclk);
    axi_rd(8'h14, rdat, resp);
    `CHK(rdat, 32'h96)
    $display("test sync done");
    tally_and_finish();
  end
endmodule
